// ---- hw/gdp_pkg.sv ----
package gdp_pkg;

   // ---------------------------------------------------------------
   // Serial frame layout
   // ---------------------------------------------------------------
   localparam int         FRAME_W    = 16;     // Bits per frame
   localparam int         CNT_W      = 5;      // Bit counter width
   localparam logic [4:0] FRAME_BITS = 5'h10;  // Complete frame
   localparam int         FR_WR_BIT  = 15;     // Write flag
   localparam int         FR_AD_MSB  = 14;     // Address field
   localparam int         FR_AD_LSB  = 8;
   localparam int         FR_DT_MSB  = 7;      // Data field
   localparam int         AD_W       = 7;
   localparam int         DATA_W     = 8;

   // ---------------------------------------------------------------
   // Device registers reached over the serial link
   // ---------------------------------------------------------------
   localparam logic [6:0] DREG_CFG   = 7'h00;  // Configuration
   localparam logic [6:0] DREG_MASK  = 7'h01;  // Fault mask
   localparam logic [6:0] DREG_WASN  = 7'h02;  // Faults routed to warning
   localparam logic [6:0] DREG_FSTAT = 7'h03;  // Live faults, read only
   localparam int         CFG_EN     = 0;      // Driver enable
   localparam int         CFG_PWM    = 1;      // Warning pin carries PWM
   localparam int         CFG_AI6    = 2;      // Input six is override state
   localparam int         CFG_AI5    = 3;      // Input five is override enable
   localparam logic [7:0] CFG_RST    = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h00;
   localparam logic [7:0] WASN_RST   = 8'h0e;

   // ---------------------------------------------------------------
   // Faults and duty-cycle output
   // ---------------------------------------------------------------
   localparam int FAULT_W  = 4;   // Cross conduction plus protection
   localparam int PROT_W   = 3;   // External protection comparators
   localparam int PWM_W    = 10;  // Conversion result width

   // ---------------------------------------------------------------
   // Device synchroniser lanes
   // ---------------------------------------------------------------
   localparam int         SY_W     = 9;
   localparam int         SY_POS   = 0;
   localparam int         SY_NEG   = 1;
   localparam int         SY_OEN   = 2;
   localparam int         SY_OST   = 3;
   localparam int         SY_SCLK  = 4;
   localparam int         SY_CS    = 5;
   localparam int         SY_SDI   = 6;
   localparam int         SY_S5    = 7;
   localparam int         SY_S6    = 8;
   localparam logic [8:0] SY_IDLE  = 9'h020;  // Chip select idles high

   // ---------------------------------------------------------------
   // Serial clock timing for the host
   // ---------------------------------------------------------------
   localparam int         CLK_PER_NS  = 10;
   localparam int         SCLK_MAX_HZ = 4_000_000;
   localparam int         SCLK_PER_NS = 1_000_000_000 / SCLK_MAX_HZ;
   localparam int         HALF_CYC    = (SCLK_PER_NS / 2 + CLK_PER_NS - 1) / CLK_PER_NS;
   localparam int         DIV_W       = 4;
   localparam logic [3:0] HALF_LD     = 4'(HALF_CYC - 1);
   localparam logic [5:0] EDGES_LAST  = 6'(2 * FRAME_W - 1);

   // ---------------------------------------------------------------
   // Host command registers
   // ---------------------------------------------------------------
   localparam int         HAD_W      = 3;
   localparam int         HDT_W      = 16;
   localparam logic [2:0] HREG_CTRL  = 3'h0;
   localparam logic [2:0] HREG_TX    = 3'h1;
   localparam logic [2:0] HREG_RX    = 3'h2;
   localparam logic [2:0] HREG_STAT  = 3'h3;
   localparam logic [2:0] HREG_ISTAT = 3'h4;
   localparam logic [2:0] HREG_ICLR  = 3'h5;
   localparam logic [2:0] HREG_IEN   = 3'h6;
   localparam int         HCTL_OEN   = 0;
   localparam int         HCTL_OST   = 1;
   localparam int         IRQ_W      = 3;
   localparam int         IRQ_ALARM  = 0;
   localparam int         IRQ_WARN   = 1;
   localparam int         IRQ_DONE   = 2;

endpackage

// ---- hw/gdp_link_if.sv ----
interface gdp_link_if;
   // Gate commands and override
   logic in_pos;
   logic in_neg;
   logic ovr_en;
   logic ovr_state;
   // Serial link
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   // Indicators
   logic fault_alarm_n;
   logic warning_out_n;

   modport host (output in_pos, in_neg, ovr_en, ovr_state, sclk, cs_n, sdi,
                 input  sdo, fault_alarm_n, warning_out_n);
   modport dev  (input  in_pos, in_neg, ovr_en, ovr_state, sclk, cs_n, sdi,
                 output sdo, fault_alarm_n, warning_out_n);
endinterface

// ---- hw/gdp_spi_shift.sv ----
module gdp_spi_shift
   import gdp_pkg::*;
(
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst,
   // Edge strobes, already gated by chip select
   input  wire logic                   fall,
   input  wire logic                   rise,
   input  wire logic                   sdi_bit,
   // Reply load at frame start
   input  wire logic                   load,
   input  wire logic [FRAME_W-1:0]     load_val,
   // Results
   output logic      [FRAME_W-1:0]     rx,
   output logic      [CNT_W-1:0]       cnt,
   output logic                        sdo
);

   typedef struct packed {
      logic [FRAME_W-1:0] rx;   // Received bits
      logic [FRAME_W-1:0] tx;   // Reply bits still to send
      logic [CNT_W-1:0]   cnt;  // Falling edges seen
      logic               sdo;  // Output bit
   } gdp_sh_t;

   gdp_sh_t sh_reg;
   gdp_sh_t sh_next;

   // ---------------------------------------------------------------
   // Shift engine
   // ---------------------------------------------------------------
   // Sample on falling, update on rising edge
   always_comb
   begin
      sh_next = sh_reg;
      if (load)
      begin
         sh_next.tx  = load_val;
         sh_next.cnt = '0;
      end
      else
      begin
         if (fall)
         begin
            sh_next.rx = {sh_reg.rx[FRAME_W-2:0], sdi_bit};
            // Saturate so an overlong frame stays recognisable
            if (sh_reg.cnt != '1)
               sh_next.cnt = sh_reg.cnt + 5'h01;
         end
         if (rise)
         begin
            sh_next.sdo = sh_reg.tx[FRAME_W-1];
            sh_next.tx  = {sh_reg.tx[FRAME_W-2:0], 1'b0};
         end
      end
   end

   // State register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         sh_reg <= '0;
      else
         sh_reg <= sh_next;
   end

   assign rx  = sh_reg.rx;
   assign cnt = sh_reg.cnt;
   assign sdo = sh_reg.sdo;

endmodule // gdp_spi_shift

// ---- hw/gdp_dev.sv ----
// Behaviour
// - Alarm low while any unmasked fault present
// - Warning low on unmasked assigned fault
// - Warning may carry conversion duty PWM
// - Override state sets source or sink
// - Override enable wins over PWM command
// - Enabled driver follows positive PWM input
// - Both PWM inputs high flags cross conduction
// - Host PWM between 1 and 50 kHz
// - Host serial clock at most 4 MHz
// - Host holds chip select low per frame
// - Serial pins ignored while chip select high
// - Data in sampled on falling clock edge
// - Data out changes on rising clock edge
// - Input six selectable as override state
// - Input five selectable as override enable
//
// The plain strobed port and the register offsets were decided locally.
module gdp_dev
   import gdp_pkg::*;
(
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst,
   // Link to the host
   gdp_link_if.dev                     lk,
   // Secondary side inputs, asynchronous
   input  wire logic                   sense_input_five,
   input  wire logic                   sense_input_six,
   // Protection comparators and conversion, same clock
   input  wire logic [PROT_W-1:0]      prot_fault,
   input  wire logic [PWM_W-1:0]       adc_result,
   // Gate drive
   output logic                        gate_source_out,
   output logic                        gate_sink_out,
   output logic                        cross_conduction_fault
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [SY_W-1:0]   s1;       // First synchroniser stage
      logic [SY_W-1:0]   s2;       // Second synchroniser stage
      logic              sclk_d;   // Previous clock level
      logic              cs_d;     // Previous chip select level
      logic [DATA_W-1:0] cfg;      // Configuration
      logic [DATA_W-1:0] mask;     // Fault mask
      logic [DATA_W-1:0] wasn;     // Faults routed to warning
      logic [AD_W-1:0]   last_ad;  // Address of the last frame
      logic [PWM_W-1:0]  pwm_cnt;  // Duty-cycle ramp
      logic              src;      // Source drive
      logic              snk;      // Sink level, low pulls gate down
      logic              xc;       // Cross conduction flag
      logic              alarm_n;
      logic              warn_n;
   } gdp_dev_t;

   localparam gdp_dev_t DEV_RST = '{
      s1: SY_IDLE, s2: SY_IDLE, sclk_d: 1'b0, cs_d: 1'b1,
      cfg: CFG_RST, mask: MASK_RST, wasn: WASN_RST, last_ad: '0,
      pwm_cnt: '0, src: 1'b0, snk: 1'b0, xc: 1'b0,
      alarm_n: 1'b1, warn_n: 1'b1};

   gdp_dev_t dv_reg;
   gdp_dev_t dv_next;

   // ---------------------------------------------------------------
   // Link decode wires
   // ---------------------------------------------------------------
   logic                   cs_act;     // Chip select low, synchronised
   logic                   sck_rise;   // Rising edge inside a frame
   logic                   sck_fall;   // Falling edge inside a frame
   logic                   fr_start;   // Chip select just fell
   logic                   fr_end;     // Chip select just rose
   logic [FRAME_W-1:0]     sh_rx;      // Received frame
   logic [CNT_W-1:0]       sh_cnt;     // Bits received
   logic                   sh_sdo;     // Output bit
   logic [FRAME_W-1:0]     reply;      // Reply loaded at frame start
   logic [DATA_W-1:0]      rd_data;    // Register addressed last frame
   logic [FAULT_W-1:0]     fault;      // Live fault vector
   logic [FAULT_W-1:0]     unmasked;   // Faults that may signal
   logic                   ovr_on;     // Override in force
   logic                   ovr_st;     // Override drive state
   logic                   xc_now;     // Both arms commanded on

   // Edges come only from the second stage and its delayed copy
   assign cs_act   = ~dv_reg.s2[SY_CS];
   assign sck_rise = cs_act & dv_reg.s2[SY_SCLK] & ~dv_reg.sclk_d;
   assign sck_fall = cs_act & ~dv_reg.s2[SY_SCLK] & dv_reg.sclk_d;
   assign fr_start = dv_reg.cs_d & ~dv_reg.s2[SY_CS];
   assign fr_end   = ~dv_reg.cs_d & dv_reg.s2[SY_CS];

   // ---------------------------------------------------------------
   // Read data of the previous frame's address
   // ---------------------------------------------------------------
   // Reads are pipelined one frame: the reply shifts out before the
   // new address is complete, so it answers the last frame's address
   always_comb
   begin
      rd_data = '0;
      if (dv_reg.last_ad == DREG_CFG)
         rd_data = dv_reg.cfg;
      else if (dv_reg.last_ad == DREG_MASK)
         rd_data = dv_reg.mask;
      else if (dv_reg.last_ad == DREG_WASN)
         rd_data = dv_reg.wasn;
      else if (dv_reg.last_ad == DREG_FSTAT)
         rd_data = DATA_W'(fault);
      else
         rd_data = '0;
   end

   // Upper byte reports live faults, lower byte the read data
   assign reply = {DATA_W'(fault), rd_data};

   // ---------------------------------------------------------------
   // Serial shifter
   // ---------------------------------------------------------------
   gdp_spi_shift u_shift
   (
      .clock    (clock),
      .rst      (rst),
      .fall     (sck_fall),
      .rise     (sck_rise),
      .sdi_bit  (dv_reg.s2[SY_SDI]),
      .load     (fr_start),
      .load_val (reply),
      .rx       (sh_rx),
      .cnt      (sh_cnt),
      .sdo      (sh_sdo)
   );

   // ---------------------------------------------------------------
   // Fault and override decode
   // ---------------------------------------------------------------
   assign xc_now   = dv_reg.s2[SY_POS] & dv_reg.s2[SY_NEG];
   assign fault    = {prot_fault, xc_now};
   assign unmasked = fault & ~dv_reg.mask[FAULT_W-1:0];
   // Secondary side may raise the override on its own
   assign ovr_on   = dv_reg.s2[SY_OEN]
                   | (dv_reg.cfg[CFG_AI5] & dv_reg.s2[SY_S5]);
   assign ovr_st   = dv_reg.cfg[CFG_AI6] ? dv_reg.s2[SY_S6]
                                         : dv_reg.s2[SY_OST];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      dv_next        = dv_reg;
      // Pins from the host and secondary side
      dv_next.s1     = {sense_input_six, sense_input_five, lk.sdi, lk.cs_n,
                        lk.sclk, lk.ovr_state, lk.ovr_en, lk.in_neg, lk.in_pos};
      dv_next.s2     = dv_reg.s1;
      dv_next.sclk_d = dv_reg.s2[SY_SCLK];
      dv_next.cs_d   = dv_reg.s2[SY_CS];

      // Only a complete frame commits; short frames are dropped
      if (fr_end && sh_cnt == FRAME_BITS)
      begin
         dv_next.last_ad = sh_rx[FR_AD_MSB:FR_AD_LSB];
         if (sh_rx[FR_WR_BIT])
         begin
            if (sh_rx[FR_AD_MSB:FR_AD_LSB] == DREG_CFG)
               dv_next.cfg = sh_rx[FR_DT_MSB:0];
            else if (sh_rx[FR_AD_MSB:FR_AD_LSB] == DREG_MASK)
               dv_next.mask = sh_rx[FR_DT_MSB:0];
            else if (sh_rx[FR_AD_MSB:FR_AD_LSB] == DREG_WASN)
               dv_next.wasn = sh_rx[FR_DT_MSB:0];
         end
      end

      // Gate drive, override first, then interlock, then PWM
      if (ovr_on)
      begin
         dv_next.src = ovr_st;
         dv_next.snk = ovr_st;
      end
      else if (xc_now)
      begin
         dv_next.src = 1'b0;
         dv_next.snk = 1'b0;
      end
      else if (dv_reg.cfg[CFG_EN])
      begin
         dv_next.src = dv_reg.s2[SY_POS];
         dv_next.snk = dv_reg.s2[SY_POS];
      end
      else
      begin
         // Disabled driver holds the gate low
         dv_next.src = 1'b0;
         dv_next.snk = 1'b0;
      end
      dv_next.xc = xc_now;

      // Alarm open when every fault is absent or masked; warning, outside PWM mode, when every assigned fault is
      dv_next.alarm_n = ~|unmasked;
      dv_next.pwm_cnt = dv_reg.pwm_cnt + 10'h001;
      if (dv_reg.cfg[CFG_PWM])
         // Duty ramp resolves one count in 2^PWM_W clocks
         dv_next.warn_n = dv_reg.pwm_cnt < adc_result;
      else
         dv_next.warn_n = ~|(unmasked & dv_reg.wasn[FAULT_W-1:0]);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         dv_reg <= DEV_RST;
      else
         dv_reg <= dv_next;
   end

   // Outputs straight from flip-flops
   assign gate_source_out        = dv_reg.src;
   assign gate_sink_out          = dv_reg.snk;
   assign cross_conduction_fault = dv_reg.xc;
   assign lk.fault_alarm_n       = dv_reg.alarm_n;
   assign lk.warning_out_n       = dv_reg.warn_n;
   assign lk.sdo                 = sh_sdo;

endmodule // gdp_dev

// ---- hw/gdp_host.sv ----
module gdp_host
   import gdp_pkg::*;
(
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst,
   // Link to the device
   gdp_link_if.host                    lk,
   // Register port
   input  wire logic [HAD_W-1:0]       addr,
   input  wire logic [HDT_W-1:0]       wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [HDT_W-1:0]       rdata,
   output logic                        irq,
   // PWM commands, same clock
   input  wire logic                   pwm_pos_cmd,
   input  wire logic                   pwm_neg_cmd
);

   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_SETUP = 2'b01,
      H_RUN   = 2'b11,
      H_HOLD  = 2'b10
   } gdp_hst_e_t;

   typedef struct packed {
      gdp_hst_e_t       st;
      logic [2:0]       s1;       // Sync stage one: sdo, alarm, warn
      logic [2:0]       s2;       // Sync stage two
      logic             alarm_d;  // Previous alarm level
      logic             warn_d;   // Previous warning level
      logic [1:0]       ctrl;     // Override enable and state
      logic [IRQ_W-1:0] ien;
      logic [IRQ_W-1:0] ist;
      logic [HDT_W-1:0] tx;
      logic [HDT_W-1:0] rx;
      logic [DIV_W-1:0] div;      // Half-period divider
      logic [5:0]       ecnt;     // Clock edges made
      logic             sclk;
      logic             cs_n;
      logic             sdi;
      logic             pos;
      logic             neg;
      logic [HDT_W-1:0] rdata;
      logic             irq;
   } gdp_hst_t;

   localparam gdp_hst_t HST_RST = '{st: H_IDLE, s1: 3'h6, s2: 3'h6,
      alarm_d: 1'b1, warn_d: 1'b1, cs_n: 1'b1, default: '0};

   gdp_hst_t hs_reg;
   gdp_hst_t hs_next;
   logic                   tick;    // Half-period elapsed
   logic [IRQ_W-1:0]       ev;      // Events this cycle

   assign tick = (hs_reg.div == '0);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      hs_next         = hs_reg;
      hs_next.s1      = {lk.warning_out_n, lk.fault_alarm_n, lk.sdo};
      hs_next.s2      = hs_reg.s1;
      hs_next.alarm_d = hs_reg.s2[1];
      hs_next.warn_d  = hs_reg.s2[2];
      hs_next.pos     = pwm_pos_cmd;  // Caller keeps 1 to 50 kHz
      hs_next.neg     = pwm_neg_cmd;
      ev              = '0;
      ev[IRQ_ALARM]   = hs_reg.alarm_d & ~hs_reg.s2[1];
      ev[IRQ_WARN]    = hs_reg.warn_d & ~hs_reg.s2[2];
      hs_next.div     = (hs_reg.st == H_IDLE || tick) ? HALF_LD : hs_reg.div - 4'h1;

      // Frame sequencer
      case (hs_reg.st)
         H_IDLE:
            // A frame write while busy is ignored
            if (wr && addr == HREG_TX)
            begin
               hs_next.tx   = wdata;
               hs_next.cs_n = 1'b0;
               hs_next.ecnt = '0;
               hs_next.st   = H_SETUP;
            end
         H_SETUP:
            if (tick)
               hs_next.st = H_RUN;
         H_RUN:
            if (tick)
            begin
               hs_next.sclk = ~hs_reg.sclk;
               hs_next.ecnt = hs_reg.ecnt + 6'h01;
               if (!hs_reg.sclk)
               begin
                  // New bit on rising edge, steady until falling edge
                  hs_next.sdi = hs_reg.tx[HDT_W-1];
                  hs_next.tx  = {hs_reg.tx[HDT_W-2:0], 1'b0};
               end
               else
                  hs_next.rx = {hs_reg.rx[HDT_W-2:0], hs_reg.s2[0]};
               if (hs_reg.ecnt == EDGES_LAST)
                  hs_next.st = H_HOLD;
            end
         H_HOLD:
            if (tick)
            begin
               hs_next.cs_n  = 1'b1;
               ev[IRQ_DONE]  = 1'b1;
               hs_next.st    = H_IDLE;
            end
         default:
            hs_next.st = H_IDLE;
      endcase

      // Register writes; a set in the clearing cycle wins
      if (wr && addr == HREG_CTRL)
         hs_next.ctrl = wdata[1:0];
      else if (wr && addr == HREG_IEN)
         hs_next.ien = wdata[IRQ_W-1:0];
      if (wr && addr == HREG_ICLR)
         hs_next.ist = (hs_reg.ist & ~wdata[IRQ_W-1:0]) | ev;
      else
         hs_next.ist = hs_reg.ist | ev;
      hs_next.irq = |(hs_reg.ist & hs_reg.ien);

      // Read data stand one cycle only
      hs_next.rdata = '0;
      if (rd && addr == HREG_CTRL)
         hs_next.rdata = HDT_W'(hs_reg.ctrl);
      else if (rd && addr == HREG_RX)
         hs_next.rdata = hs_reg.rx;
      else if (rd && addr == HREG_STAT)
         hs_next.rdata = HDT_W'({hs_reg.s2[2], hs_reg.s2[1], hs_reg.st != H_IDLE});
      else if (rd && addr == HREG_ISTAT)
         hs_next.rdata = HDT_W'(hs_reg.ist);
      else if (rd && addr == HREG_IEN)
         hs_next.rdata = HDT_W'(hs_reg.ien);
   end

   // State register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         hs_reg <= HST_RST;
      else
         hs_reg <= hs_next;
   end

   assign lk.in_pos    = hs_reg.pos;
   assign lk.in_neg    = hs_reg.neg;
   assign lk.ovr_en    = hs_reg.ctrl[HCTL_OEN];
   assign lk.ovr_state = hs_reg.ctrl[HCTL_OST];
   assign lk.sclk      = hs_reg.sclk;
   assign lk.cs_n      = hs_reg.cs_n;
   assign lk.sdi       = hs_reg.sdi;
   assign rdata        = hs_reg.rdata;
   assign irq          = hs_reg.irq;

endmodule // gdp_host

// ---- test/gdp_link_props.sv ----
module gdp_link_props
(
   // Clock and reset
   input wire logic                     clock,
   input wire logic                     rst,
   // Link wires
   input wire logic                     in_pos,
   input wire logic                     in_neg,
   input wire logic                     ovr_en,
   input wire logic                     ovr_state,
   input wire logic                     sclk,
   input wire logic                     cs_n,
   input wire logic                     sdo,
   input wire logic                     fault_alarm_n,
   input wire logic                     warning_out_n,
   // Device side
   input wire logic                     gate_source_out,
   input wire logic                     gate_sink_out,
   input wire logic                     cross_conduction_fault,
   input wire logic [gdp_pkg::PROT_W-1:0] prot_fault
);
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------
   // Checks, mask kept at reset value by the bench
   // -----------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_cs_idle_clk: assert property (cs_n |-> !sclk)
      else $error("serial clock moved outside frame");
   a_sdo_quiet: assert property (cs_n [*4] |-> $stable(sdo))
      else $error("data out moved without chip select");
   a_sdo_low_hold: assert property ((!sclk && !cs_n) [*6] |-> $stable(sdo))
      else $error("data out moved away from rising clock");
   a_xc_flag: assert property ((in_pos && in_neg) [*5] |-> cross_conduction_fault)
      else $error("overlap not flagged");
   a_xc_gate_off: assert property (!ovr_en [*4] ##0 cross_conduction_fault
      |-> !gate_source_out && !gate_sink_out)
      else $error("gate not off on overlap");
   a_ovr_high: assert property ((ovr_en && ovr_state) [*4] |-> gate_source_out)
      else $error("override high not driven");
   a_ovr_low: assert property ((ovr_en && !ovr_state) [*4] |-> !gate_sink_out)
      else $error("override low not driven");
   a_alarm_xc: assert property (cross_conduction_fault [*3] |-> !fault_alarm_n)
      else $error("alarm not low on fault");
   a_alarm_idle: assert property ((!cross_conduction_fault && prot_fault == 3'h0) [*4]
      |-> fault_alarm_n)
      else $error("alarm low without fault");
   a_warn_prot: assert property ((prot_fault != 3'h0) [*3] |-> !warning_out_n)
      else $error("warning not low on fault");
   cover property (cross_conduction_fault);
   cover property (ovr_en && ovr_state);
   cover property ($rose(cs_n));
endmodule // gdp_link_props

// ---- test/gdp_tb.sv ----
module testbench
   import gdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------
   // Bench signals
   // -----------------------------------------------------------
   logic              clock, rst, h_wr, h_rd, irq, pos, neg, src, snk, xc, s5, s6;
   logic [PWM_W-1:0]  adc;
   logic [HAD_W-1:0]  addr;
   logic [HDT_W-1:0]  wdata, rdata, r;
   logic [PROT_W-1:0] prot;
   int                failures, check_count;
   gdp_link_if        lk ();
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
   gdp_host i_gdp_host (.clock(clock), .rst(rst), .lk(lk.host), .addr(addr), .wdata(wdata),
      .wr(h_wr), .rd(h_rd), .rdata(rdata), .irq(irq), .pwm_pos_cmd(pos), .pwm_neg_cmd(neg));
   gdp_dev i_gdp_dev (.clock(clock), .rst(rst), .lk(lk.dev), .sense_input_five(s5),
      .sense_input_six(s6), .prot_fault(prot), .adc_result(adc),
      .gate_source_out(src), .gate_sink_out(snk), .cross_conduction_fault(xc));
   gdp_link_props i_props (.clock(clock), .rst(rst), .in_pos(lk.in_pos), .in_neg(lk.in_neg),
      .ovr_en(lk.ovr_en), .ovr_state(lk.ovr_state), .sclk(lk.sclk), .cs_n(lk.cs_n),
      .sdo(lk.sdo), .fault_alarm_n(lk.fault_alarm_n), .warning_out_n(lk.warning_out_n),
      .gate_source_out(src), .gate_sink_out(snk), .cross_conduction_fault(xc),
      .prot_fault(prot));
   // Free running clock
   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task tick(input int n); repeat (n) @(posedge clock); endtask
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock); addr <= a; wdata <= d; h_wr <= 1; @(posedge clock); h_wr <= 0;
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clock); addr <= a; h_rd <= 1; @(posedge clock); h_rd <= 0; #1 d = rdata;
   endtask
   // One frame, polled on busy with a bounded count
   task frame(input logic [15:0] w, output logic [15:0] q);
      logic [15:0] s;
      wr(HREG_TX, w); s = 16'h0001;
      repeat (60) if (s[0] === 1'b1) begin tick(10); rd(HREG_STAT, s); end
      `CHK("frame end", 1'b0, s[0])
      tick(5); rd(HREG_RX, q);
   endtask
   task t_gate();
      frame(16'h8001, r); tick(1); pos <= 1; tick(8);
      `CHK("src on", 1'b1, src)
      pos <= 0; tick(8);
      `CHK("snk off", 1'b0, snk)
   endtask
   task t_cross();
      // Interrupt lags the pins by two syncs and four registers
      wr(HREG_IEN, 16'h0001); tick(1); pos <= 1; neg <= 1; tick(10);
      `CHK("xc", 1'b1, xc)
      `CHK("gate off", 2'b00, {src, snk})
      `CHK("alarm", 1'b0, lk.fault_alarm_n)
      `CHK("irq", 1'b1, irq)
      pos <= 0; neg <= 0; tick(8); wr(HREG_ICLR, 16'h0007); tick(3);
      `CHK("irq clr", 1'b0, irq)
      `CHK("alarm off", 1'b1, lk.fault_alarm_n)
   endtask
   task t_ovr();
      wr(HREG_CTRL, 16'h0003); tick(8);
      `CHK("ovr hi", 2'b11, {src, snk})
      wr(HREG_CTRL, 16'h0001); pos <= 1; tick(8);
      `CHK("ovr lo", 2'b00, {src, snk})
      wr(HREG_CTRL, 16'h0000); pos <= 0;
   endtask
   task t_link();
      prot <= 3'h2; tick(8);
      `CHK("warn", 1'b0, lk.warning_out_n)
      frame(16'h0300, r); frame(16'h0000, r);
      `CHK("reply", 16'h0404, r)
      rd(3'h7, r);
      `CHK("unmapped", 16'h0000, r)
      prot <= 3'h0;
   endtask
   // Secondary side override and duty-cycle copy on the warning pin
   task t_sense();
      int hi;
      frame(16'h800f, r); s5 <= 1; s6 <= 1; adc <= 10'h100; tick(8);
      `CHK("in6 ovr", 2'b11, {src, snk})
      hi = 0;
      // One full ramp holds exactly the conversion value of high cycles
      repeat (1024) begin tick(1); hi += lk.warning_out_n; end
      `CHK("duty", 256, hi)
      s6 <= 0; tick(8);
      `CHK("in6 low", 2'b00, {src, snk})
   endtask
   task complete_run();
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence after three reset cycles
   initial
   begin
      rst = 1; addr = 0; wdata = 0; h_wr = 0; h_rd = 0; pos = 0; neg = 0; prot = 0;
      s5 = 0; s6 = 0; adc = 0;
      tick(3); rst <= 0;
      t_gate(); t_cross(); t_ovr(); t_link(); t_sense();
      complete_run();
   end
   // Hang guard, well past four frames
   initial
   begin
      #100000; failures++; complete_run();
   end
endmodule // testbench
